// File: liu_map.svh
// Register offsets, field positions, reset values and timing figures of
// the line interface global control block.
// Assumes a byte-addressed AXI4-Lite slave with one 32-bit word per register.
`ifndef LIU_MAP_SVH
`define LIU_MAP_SVH

// ============================================================
// Register byte offsets
`define LIU_CTRL_OFS      8'h00
`define LIU_STATUS_OFS    8'h04
`define LIU_MASK_OFS      8'h08
`define LIU_LOS_OFS       8'h0c
`define LIU_VIEW_OFS      8'h10

// ============================================================
// Control register fields
`define LIU_CTRL_AO_BIT   0
`define LIU_CTRL_GIE_BIT  1
`define LIU_CTRL_JA_LSB   2
`define LIU_CTRL_RATE_LSB 4
`define LIU_CTRL_WIDTH    6
`define LIU_CTRL_RST      6'h00

// ============================================================
// Reset values of the event registers
`define LIU_STATUS_RST    16'h0000
`define LIU_MASK_RST      16'h0000

// ============================================================
// Jitter attenuator figures, bandwidth in tenths of a hertz
`define LIU_JA_FIFO_SHORT 7'h20
`define LIU_JA_FIFO_LONG  7'h40
`define LIU_JA_BW_T1      7'h1e
`define LIU_JA_BW_E1      7'h64
`define LIU_JA_BW_E1_NAR  7'h0f

// ============================================================
// Clock figures in kHz
`define LIU_ACLK_KHZ      40000
`define LIU_E1_KHZ        2048
`define LIU_T1_KHZ        1544

// AXI responses
`define LIU_RESP_OKAY     2'h0
`define LIU_RESP_SLVERR   2'h2

`endif

// File: liu_pkg.sv
// Types shared by the line interface global control block.
// Assumes liu_map.svh supplies the numeric constants.
`default_nettype none
package liu_pkg;

	// ============================================================
	// Jitter attenuator placement
	typedef enum logic [1:0] {
		LIU_JA_OFF    = 2'b00,
		LIU_JA_TX     = 2'b01,
		LIU_JA_RX     = 2'b10,
		LIU_JA_RX_NAR = 2'b11
	} liu_ja_t;

	// Common line rate of all channels
	typedef enum logic [1:0] {
		LIU_RATE_T1 = 2'b00,
		LIU_RATE_E1 = 2'b01,
		LIU_RATE_J1 = 2'b10
	} liu_rate_t;

endpackage
`default_nettype wire

// File: liu_ja_decode.sv
// Jitter attenuator select decoder: FIFO depth and loop bandwidth.
// Assumes the caller registers the outputs.
`timescale 1ns/1ps
`default_nettype none
`include "liu_map.svh"

module liu_ja_decode
	import liu_pkg::*;
(
	// Select and rate
	input  wire liu_ja_t   sel,
	input  wire liu_rate_t rate,
	// Decoded figures
	output logic [6:0]     fifo_depth,
	output logic [6:0]     bw_dhz
);

	// ============================================================
	// Decode
	wire       is_e1_w  = (rate == LIU_RATE_E1);
	wire [6:0] wide_bw_w = is_e1_w ? `LIU_JA_BW_E1 : `LIU_JA_BW_T1;

	// Narrow mode only narrows E1; T1 keeps its single figure
	assign fifo_depth = (sel == LIU_JA_OFF)    ? 7'h00 :
	                    (sel == LIU_JA_RX_NAR) ? `LIU_JA_FIFO_LONG :
	                                             `LIU_JA_FIFO_SHORT;
	assign bw_dhz     = (sel == LIU_JA_OFF)    ? 7'h00 :
	                    (sel == LIU_JA_RX_NAR && is_e1_w) ? `LIU_JA_BW_E1_NAR :
	                                             wide_bw_w;

endmodule
`default_nettype wire

// File: liu_clk_synth.sv
// Master clock output: follows the T1 reference in T1/J1, NCO in E1.
// Assumes the T1 reference input is synchronous to aclk.
`timescale 1ns/1ps
`default_nettype none
`include "liu_map.svh"

module liu_clk_synth
	import liu_pkg::*;
#(
	parameter int ACC_W = 16
)
(
	// Clock, reset, enable
	input  wire logic      aclk,
	input  wire logic      aresetn,
	input  wire logic      clk_en,
	// Rate and reference
	input  wire liu_rate_t rate,
	input  wire logic      t1_ref,
	// Synthesized clock
	output logic           clk_out
);

	// ============================================================
	// Elaboration check
	generate
		if (ACC_W < 8 || ACC_W > 24)
		begin : g_chk
			$error("ACC_W out of range");
		end
	endgenerate

	// E1 phase step; the NCO jitters by one aclk period, a trade for no PLL
	localparam logic [ACC_W-1:0] E1_INC =
		ACC_W'((64'(`LIU_E1_KHZ) << ACC_W) / 64'(`LIU_ACLK_KHZ));

	logic [ACC_W-1:0] acc_ff;
	logic             clk_out_ff;
	wire  [ACC_W-1:0] nxt_acc = acc_ff + E1_INC;
	wire              is_e1_w = (rate == LIU_RATE_E1);

	// ============================================================
	// [R9] Rate follows mode
	// [R10] T1 timing from external reference
	wire nxt_clk_out = is_e1_w ? nxt_acc[ACC_W-1] : t1_ref;

	// Phase accumulator and output flop
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			acc_ff     <= '0;
			clk_out_ff <= 1'b0;
		end
		else if (clk_en)
		begin
			acc_ff     <= nxt_acc;
			clk_out_ff <= nxt_clk_out;
		end
	end

	assign clk_out = clk_out_ff;

	// ============================================================
	// Checks
	t1_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en && !is_e1_w |=> clk_out_ff == $past(t1_ref)) // [R9]
		else $error("T1 clock output does not follow reference");

endmodule
`default_nettype wire

// File: liu_global_ctrl.sv
// Global control of a multi-channel T1/E1/J1 line interface: all-ones on
// loss of signal, alarm interrupt, jitter attenuator and clock selection.
// Assumes straps and loss-of-signal inputs are synchronous to aclk.
//
// What this block does
// [R1] Hardware mode strap sends all-ones on loss
// [R2] Host mode control bit enables all-ones
// [R3] Alarm status change pulls interrupt low
// [R4] Reading status releases the interrupt
// [R5] No interrupt without global enable bit
// [R6] Interrupt pin drives low only
// [R7] Two-bit select sets path, bandwidth, FIFO
// [R8] Unconnected select defaults to disabled
// [R9] Master clock output at mode rate
// [R10] Outside supplies 1.544 MHz T1 reference
// [R11] All channels share one line rate
// [R12] Mode select low means host mode
// [R13] All-ones per channel, ends with loss
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "liu_map.svh"

module liu_global_ctrl
	import liu_pkg::*;
#(
	parameter int NCH = 8
)
(
	// Clock, reset, enable
	input  wire logic            aclk,
	input  wire logic            aresetn,
	input  wire logic            clk_en,
	// AXI4-Lite write
	input  wire logic [7:0]      s_axi_awaddr,
	input  wire logic            s_axi_awvalid,
	output logic                 s_axi_awready,
	input  wire logic [31:0]     s_axi_wdata,
	input  wire logic [3:0]      s_axi_wstrb,
	input  wire logic            s_axi_wvalid,
	output logic                 s_axi_wready,
	output logic [1:0]           s_axi_bresp,
	output logic                 s_axi_bvalid,
	input  wire logic            s_axi_bready,
	// AXI4-Lite read
	input  wire logic [7:0]      s_axi_araddr,
	input  wire logic            s_axi_arvalid,
	output logic                 s_axi_arready,
	output logic [31:0]          s_axi_rdata,
	output logic [1:0]           s_axi_rresp,
	output logic                 s_axi_rvalid,
	input  wire logic            s_axi_rready,
	// Straps
	input  wire logic            config_mode_select,
	input  wire logic            auto_all_ones_on_los,
	input  wire logic            jitter_path_select_lsb,
	input  wire logic            jitter_path_select_msb,
	input  wire logic [1:0]      line_rate_strap,
	// Line side
	input  wire logic [NCH-1:0]  channel_los,
	output logic [NCH-1:0]       tx_all_ones,
	// Clocks
	input  wire logic            t1_reference_clock_in,
	output logic                 synth_master_clock_out,
	// Jitter attenuator setting
	output liu_ja_t              jitter_path,
	output logic [6:0]           jitter_fifo_depth,
	output logic [6:0]           jitter_bw_dhz,
	// Open-drain interrupt
	output logic                 int_n_out,
	output logic                 int_n_oe
);

	// ============================================================
	// Elaboration check
	generate
		if (NCH < 1 || NCH > 16)
		begin : g_chk
			$error("NCH must be 1 to 16");
		end
	endgenerate

	// Byte-lane merge, shared by control and mask writes
	function automatic logic [31:0] merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				r[i*8 +: 8] = new_v[i*8 +: 8];
		end
		return r;
	endfunction

	// Unused rate code folds onto T1 so only legal rates leave the block
	function automatic liu_rate_t fix_rate(input logic [1:0] code);
		return (code == 2'b11) ? LIU_RATE_T1 : liu_rate_t'(code);
	endfunction

	// ============================================================
	// Registers
	logic [`LIU_CTRL_WIDTH-1:0] ctrl_ff;
	logic [15:0]                status_ff;
	logic [15:0]                mask_ff;
	logic [NCH-1:0]             los_prev_ff;
	logic [NCH-1:0]             tx_all_ones_ff;
	logic                       int_n_oe_ff;
	logic                       int_n_out_ff;
	liu_ja_t                    ja_path_ff;
	logic [6:0]                 ja_depth_ff;
	logic [6:0]                 ja_bw_ff;
	logic                       aw_hold_ff;
	logic                       w_hold_ff;
	logic [7:0]                 awaddr_ff;
	logic [31:0]                wdata_ff;
	logic [3:0]                 wstrb_ff;
	logic                       awready_ff;
	logic                       wready_ff;
	logic                       bvalid_ff;
	logic [1:0]                 bresp_ff;
	logic                       arready_ff;
	logic                       rvalid_ff;
	logic [31:0]                rdata_ff;
	logic [1:0]                 rresp_ff;

	// ============================================================
	// Mode selection
	// [R12] Low pin selects host mode
	wire host_w = ~config_mode_select;

	// [R2] Host bit replaces strap
	wire ao_en_w = host_w ? ctrl_ff[`LIU_CTRL_AO_BIT] : auto_all_ones_on_los;

	// [R7] Jitter select source
	// [R8] Control reset value selects disabled
	wire liu_ja_t ja_sel_w = host_w ?
		liu_ja_t'(ctrl_ff[`LIU_CTRL_JA_LSB +: 2]) :
		liu_ja_t'({jitter_path_select_msb, jitter_path_select_lsb});

	// [R11] One rate for every channel
	wire liu_rate_t rate_w = host_w ?
		fix_rate(ctrl_ff[`LIU_CTRL_RATE_LSB +: 2]) : fix_rate(line_rate_strap);

	// [R5] Interrupt only with global enable
	wire irq_allow_w = host_w & ctrl_ff[`LIU_CTRL_GIE_BIT];

	// ============================================================
	// Jitter decode and clock synthesizer
	wire [6:0] ja_depth_w;
	wire [6:0] ja_bw_w;

	liu_ja_decode u_ja
	(
		.sel        (ja_sel_w),
		.rate       (rate_w),
		.fifo_depth (ja_depth_w),
		.bw_dhz     (ja_bw_w)
	);

	liu_clk_synth u_clk
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.clk_en  (clk_en),
		.rate    (rate_w),
		.t1_ref  (t1_reference_clock_in),
		.clk_out (synth_master_clock_out)
	);

	// ============================================================
	// AXI handshakes; a write commits once address and data are both held
	wire aw_fire_w = s_axi_awvalid & awready_ff;
	wire w_fire_w  = s_axi_wvalid & wready_ff;
	wire wr_do_w   = aw_hold_ff & w_hold_ff & ~bvalid_ff;
	wire ar_fire_w = s_axi_arvalid & arready_ff;

	wire nxt_aw_hold = (aw_hold_ff | aw_fire_w) & ~wr_do_w;
	wire nxt_w_hold  = (w_hold_ff | w_fire_w) & ~wr_do_w;
	wire nxt_bvalid  = wr_do_w | (bvalid_ff & ~s_axi_bready);
	wire nxt_rvalid  = ar_fire_w | (rvalid_ff & ~s_axi_rready);

	// Write decode
	wire [5:0] wr_idx_w  = awaddr_ff[7:2];
	wire       wr_ctrl_w = wr_do_w & (wr_idx_w == `LIU_CTRL_OFS >> 2);
	wire       wr_stat_w = wr_do_w & (wr_idx_w == `LIU_STATUS_OFS >> 2);
	wire       wr_mask_w = wr_do_w & (wr_idx_w == `LIU_MASK_OFS >> 2);
	wire       wr_ok_w   = wr_ctrl_w | wr_stat_w | wr_mask_w;

	// Read decode; live and view registers are read only
	wire [5:0] rd_idx_w  = s_axi_araddr[7:2];
	wire       rd_ctrl_w = (rd_idx_w == `LIU_CTRL_OFS >> 2);
	wire       rd_stat_w = (rd_idx_w == `LIU_STATUS_OFS >> 2);
	wire       rd_mask_w = (rd_idx_w == `LIU_MASK_OFS >> 2);
	wire       rd_los_w  = (rd_idx_w == `LIU_LOS_OFS >> 2);
	wire       rd_view_w = (rd_idx_w == `LIU_VIEW_OFS >> 2);
	wire       rd_ok_w   = rd_ctrl_w | rd_stat_w | rd_mask_w | rd_los_w |
	                       rd_view_w;
	wire [31:0] view_w   = {26'h0, rate_w, ja_sel_w, host_w, ao_en_w};
	wire [31:0] nxt_rdata =
		rd_ctrl_w ? {26'h0000000, ctrl_ff} :
		rd_stat_w ? {16'h0000, status_ff} :
		rd_mask_w ? {16'h0000, mask_ff} :
		rd_los_w  ? 32'(channel_los) :
		rd_view_w ? view_w : 32'h00000000;

	// ============================================================
	// Alarm events
	// Only implemented channels may hold status or mask bits
	wire [NCH-1:0] ones_w = '1;
	wire [15:0] los_chg_w = 16'(channel_los ^ los_prev_ff);
	wire [15:0] chan_w    = 16'(ones_w);

	// [R4] A status read clears what it returned
	wire [15:0] rd_clr_w  = (ar_fire_w & rd_stat_w) ? status_ff : 16'h0000;
	wire [15:0] wr_clr_w  = wr_stat_w ? wdata_ff[15:0] : 16'h0000;

	// [R3] Any change sets a sticky bit; a set beats a clear
	wire [15:0] nxt_status =
		((status_ff & ~(rd_clr_w | wr_clr_w)) | los_chg_w) & chan_w;

	// Merged words are cut to the register widths on purpose
	wire [31:0] ctrl_mrg_w = merge(32'(ctrl_ff), wdata_ff, wstrb_ff);
	wire [31:0] mask_mrg_w = merge({16'h0000, mask_ff}, wdata_ff, wstrb_ff);
	wire [`LIU_CTRL_WIDTH-1:0] nxt_ctrl = ctrl_mrg_w[`LIU_CTRL_WIDTH-1:0];
	wire [15:0] nxt_mask = mask_mrg_w[15:0] & chan_w;

	// [R1] Strap or control bit gates loss per channel
	// [R13] Insertion tracks each channel's loss
	wire [NCH-1:0] nxt_all_ones = channel_los & {NCH{ao_en_w}};

	// [R3] Low while an enabled status bit stands
	// [R5] Global enable gates the output
	wire nxt_int_oe = irq_allow_w & |(status_ff & mask_ff);

	// ============================================================
	// AXI slave state
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_ff <= 1'b0;
			w_hold_ff  <= 1'b0;
			awready_ff <= 1'b0;
			wready_ff  <= 1'b0;
			bvalid_ff  <= 1'b0;
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b0;
		end
		else if (clk_en)
		begin
			aw_hold_ff <= nxt_aw_hold;
			w_hold_ff  <= nxt_w_hold;
			awready_ff <= ~nxt_aw_hold & ~nxt_bvalid;
			wready_ff  <= ~nxt_w_hold & ~nxt_bvalid;
			bvalid_ff  <= nxt_bvalid;
			arready_ff <= ~nxt_rvalid;
			rvalid_ff  <= nxt_rvalid;
		end
	end

	// AXI payload capture; held data and responses are also cleared on reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awaddr_ff <= 8'h00;
			wdata_ff  <= 32'h00000000;
			wstrb_ff  <= 4'h0;
			bresp_ff  <= `LIU_RESP_OKAY;
			rdata_ff  <= 32'h00000000;
			rresp_ff  <= `LIU_RESP_OKAY;
		end
		else if (clk_en)
		begin
			if (aw_fire_w)
				awaddr_ff <= s_axi_awaddr;
			if (w_fire_w)
			begin
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
			if (wr_do_w)
				bresp_ff <= wr_ok_w ? `LIU_RESP_OKAY : `LIU_RESP_SLVERR;
			if (ar_fire_w)
			begin
				rdata_ff <= nxt_rdata;
				rresp_ff <= rd_ok_w ? `LIU_RESP_OKAY : `LIU_RESP_SLVERR;
			end
		end
	end

	// ============================================================
	// Control, events and outputs
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_ff        <= `LIU_CTRL_RST;
			status_ff      <= `LIU_STATUS_RST;
			mask_ff        <= `LIU_MASK_RST;
			los_prev_ff    <= '0;
			tx_all_ones_ff <= '0;
			int_n_oe_ff    <= 1'b0;
			int_n_out_ff   <= 1'b0;
			ja_path_ff     <= LIU_JA_OFF;
			ja_depth_ff    <= 7'h00;
			ja_bw_ff       <= 7'h00;
		end
		else if (clk_en)
		begin
			if (wr_ctrl_w)
				ctrl_ff <= nxt_ctrl;
			if (wr_mask_w)
				mask_ff <= nxt_mask[15:0];
			status_ff      <= nxt_status;
			los_prev_ff    <= channel_los;
			tx_all_ones_ff <= nxt_all_ones;
			// [R6] Only the low level is driven
			int_n_out_ff   <= 1'b0;
			int_n_oe_ff    <= nxt_int_oe;
			ja_path_ff     <= ja_sel_w;
			ja_depth_ff    <= ja_depth_w;
			ja_bw_ff       <= ja_bw_w;
		end
	end

	// Port assignments
	assign s_axi_awready     = awready_ff;
	assign s_axi_wready      = wready_ff;
	assign s_axi_bvalid      = bvalid_ff;
	assign s_axi_bresp       = bresp_ff;
	assign s_axi_arready     = arready_ff;
	assign s_axi_rvalid      = rvalid_ff;
	assign s_axi_rdata       = rdata_ff;
	assign s_axi_rresp       = rresp_ff;
	assign tx_all_ones       = tx_all_ones_ff;
	assign int_n_out         = int_n_out_ff;
	assign int_n_oe          = int_n_oe_ff;
	assign jitter_path       = ja_path_ff;
	assign jitter_fifo_depth = ja_depth_ff;
	assign jitter_bw_dhz     = ja_bw_ff;

	// ============================================================
	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence chg_seen_s;
		clk_en && !wr_do_w && irq_allow_w && |(los_chg_w & mask_ff)
		##1 clk_en && !wr_do_w;
	endsequence

	hw_all_ones_a: assert property (clk_en && !host_w && // [R1]
		auto_all_ones_on_los |=> tx_all_ones_ff == $past(channel_los))
		else $error("All-ones not following loss in hardware mode");
	host_ones_off_a: assert property (clk_en && host_w && // [R2]
		!ctrl_ff[`LIU_CTRL_AO_BIT] |=> tx_all_ones_ff == '0)
		else $error("All-ones sent while host bit is clear");
	irq_raise_a: assert property (chg_seen_s |=> int_n_oe_ff) // [R3]
		else $error("Interrupt not raised after alarm change");
	irq_release_a: assert property (clk_en && status_ff == 16'h0000 // [R4]
		|=> !int_n_oe_ff)
		else $error("Interrupt held with no status pending");
	irq_gate_a: assert property (clk_en && !irq_allow_w // [R5]
		|=> !int_n_oe_ff)
		else $error("Interrupt without global enable");
	open_drain_a: assert property (int_n_oe_ff |-> !int_n_out_ff) // [R6]
		else $error("Interrupt pin driven high");
	ja_decode_a: assert property (clk_en && ja_sel_w == LIU_JA_RX_NAR // [R7]
		|=> jitter_fifo_depth == `LIU_JA_FIFO_LONG)
		else $error("Narrow receive mode without long FIFO");
	ja_off_a: assert property (clk_en && ja_sel_w == LIU_JA_OFF // [R7]
		|=> jitter_fifo_depth == 7'h00 && jitter_bw_dhz == 7'h00)
		else $error("Disabled attenuator reports a FIFO");
	rate_legal_a: assert property (rate_w != liu_rate_t'(2'b11)) // [R11]
		else $error("Illegal common line rate");
	set_wins_a: assert property (clk_en && |los_chg_w // [R3]
		|=> (status_ff & $past(los_chg_w)) == $past(los_chg_w))
		else $error("Alarm change lost against a clear");
	bvalid_hold_a: assert property (bvalid_ff && !s_axi_bready
		|=> bvalid_ff)
		else $error("Write response dropped before bready");

endmodule
`default_nettype wire

// File: liu_line_model.sv
// Line-side partner: free-running T1 reference clock for the device.
// Assumes aclk at 40 MHz; the reference is built on that clock.
`timescale 1ns/1ps
`default_nettype none

module liu_line_model
#(
	parameter int HALF = 13
)
(
	// Clock
	input  wire logic aclk,
	// Reference to the device
	output logic      t1_ref
);
	int cnt_ff = 0;

	// ============================================================
	// Reference oscillator
	// T1 reference supplied
	// 13 cycles a half period is about 1.538 MHz: close enough for
	// edge counting, and it runs free like a real oscillator
	initial t1_ref = 1'b0;
	always @(posedge aclk)
	begin
		cnt_ff <= (cnt_ff == HALF - 1) ? 0 : cnt_ff + 1;
		if (cnt_ff == HALF - 1)
			t1_ref <= ~t1_ref;
	end
endmodule
`default_nettype wire

// File: tb_liu_global_ctrl.sv
// Testbench of the global control block against a small reference model.
// Assumes a 40 MHz aclk and the byte offsets of liu_map.svh.
`timescale 1ns/1ps
`default_nettype none
`include "liu_map.svh"

module tb_liu_global_ctrl
	import liu_pkg::*;
;
	localparam int NCH = 8;
	// ============================================================
	// Signals and model state
	logic           aclk = 1'b0, aresetn = 1'b0;
	logic [7:0]     awaddr = '0, araddr = '0;
	logic [31:0]    wdata = '0, rdata, d;
	logic           awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic           arvalid = 1'b0, rready = 1'b0;
	logic           awready, wready, bvalid, arready, rvalid;
	logic [1:0]     bresp, rresp, r, rate_s = '0;
	logic           mode_s = 1'b1, ao_s = 1'b0, js0 = 1'b0, js1 = 1'b0;
	logic           en = 1'b1;
	logic [NCH-1:0] los = '0, txo;
	logic           t1r, mclk, irq_o, irq_oe;
	liu_ja_t        jpath;
	logic [6:0]     jfifo, jbw;
	int             failures = 0, cmp_count = 0, cyc = 0, status_m = 0;
	// Pull-up on the open-drain interrupt line
	wire            irq_n = irq_oe ? irq_o : 1'b1;

	always #12.5 aclk = ~aclk;

	liu_line_model i_liu_line_model (.aclk(aclk), .t1_ref(t1r));

	liu_global_ctrl #(.NCH(NCH)) i_liu_global_ctrl (
		.aclk(aclk), .aresetn(aresetn), .clk_en(en),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.config_mode_select(mode_s), .auto_all_ones_on_los(ao_s),
		.jitter_path_select_lsb(js0), .jitter_path_select_msb(js1),
		.line_rate_strap(rate_s), .channel_los(los), .tx_all_ones(txo),
		.t1_reference_clock_in(t1r), .synth_master_clock_out(mclk),
		.jitter_path(jpath), .jitter_fifo_depth(jfifo),
		.jitter_bw_dhz(jbw), .int_n_out(irq_o), .int_n_oe(irq_oe));

	// ============================================================
	// Bench tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count = cmp_count + 1;
		if (seen !== exp)
		begin
			failures = failures + 1;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		if (failures == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// Address and data offered together, each dropped once taken
	task automatic axw(input logic [7:0] a, input logic [31:0] v);
		bit ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ad && wd))
		begin
			@(posedge aclk);
			ad = ad || awready === 1'b1;
			wd = wd || wready === 1'b1;
			if (ad) awvalid <= 1'b0;
			if (wd) wvalid <= 1'b0;
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		// bready stays up between writes, so no second edge is needed
		r = bresp;
	endtask

	task automatic axr(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
	endtask

	// Every change of a loss bit is an alarm event in the model
	task automatic set_los(input logic [NCH-1:0] v);
		status_m = status_m | int'(los ^ v);
		los <= v;
		tick(1);
	endtask

	task automatic rd_status();
		axr(`LIU_STATUS_OFS);
		chk(d, status_m);
		chk(r, `LIU_RESP_OKAY);
		status_m = 0;
	endtask

	function automatic int ja_bw(int c, int rt);
		if (c == 0) return 0;
		if (rt != 1) return `LIU_JA_BW_T1;
		return c == 3 ? `LIU_JA_BW_E1_NAR : `LIU_JA_BW_E1;
	endfunction

	task automatic count_clk(input int n, output int co, output int cr);
		logic po, pr;
		co = 0;
		cr = 0;
		po = mclk;
		pr = t1r;
		repeat (n)
		begin
			@(posedge aclk);
			if (mclk === 1'b1 && po === 1'b0) co++;
			if (t1r === 1'b1 && pr === 1'b0) cr++;
			po = mclk;
			pr = t1r;
		end
	endtask

	// Hang guard: the sequence needs about 12500 cycles
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			failures = failures + 1;
			summarize();
		end
	end

	// ============================================================
	// Main sequence
	initial
	begin
		int sv, co, cr, ex;
		sv = $urandom(32'h7fdaac5b);
		tick(16);
		aresetn <= 1'b1;
		tick(2);
		axr(`LIU_CTRL_OFS);
		chk(d, `LIU_CTRL_RST);
		chk(jpath, LIU_JA_OFF);
		axr(`LIU_MASK_OFS);
		chk(d, `LIU_MASK_RST);
		axr(8'h14);
		chk(r, `LIU_RESP_SLVERR);
		chk(d, 32'h0);
		axw(`LIU_LOS_OFS, 32'hff);
		chk(r, `LIU_RESP_SLVERR);
		// codes in both modes; jitter select straps are decoys in host mode
		for (int m = 0; m < 2; m++)
			for (int rt = 0; rt < 3; rt++)
				for (int c = 0; c < 4; c++)
				begin
					mode_s <= m[0];
					rate_s <= rt[1:0];
					js0 <= c[0] ^ !m[0];
					js1 <= c[1] ^ !m[0];
					if (m == 0) axw(`LIU_CTRL_OFS, rt * 16 + c * 4);
					tick(3);
					chk(jpath, c);
					chk(jfifo, c == 0 ? 0 : c == 3 ? 64 : 32);
					chk(jbw, ja_bw(c, rt));
					axr(`LIU_VIEW_OFS);
					chk(d, rt * 16 + c * 4 + (m == 0 ? 2 : 0));
				end
		// enable comes from strap or register by mode
		for (int k = 0; k < 8; k++)
		begin
			mode_s <= k[0];
			ao_s <= k[1];
			axw(`LIU_CTRL_OFS, k[2]);
			repeat (2)
			begin
				set_los(NCH'($urandom));
				tick(1);
				chk(txo, (k[0] ? k[1] : k[2]) ? los : '0);
				axr(`LIU_LOS_OFS);
				chk(d, los);
			end
		end
		// Enable low freezes every flop, all-ones outputs included
		en <= 1'b0;
		d = txo;
		set_los(~los);
		tick(2);
		chk(txo, d);
		en <= 1'b1;
		tick(2);
		chk(txo, los);
		mode_s <= 1'b0;
		rd_status();
		sv = $urandom;
		axw(`LIU_MASK_OFS, sv);
		chk(r, `LIU_RESP_OKAY);
		axr(`LIU_MASK_OFS);
		chk(d, sv & 32'hff);
		axw(`LIU_MASK_OFS, 32'hff);
		axw(`LIU_CTRL_OFS, 32'h0);
		set_los(los ^ 8'h01);
		tick(3);
		chk(irq_n, 1'b1);
		rd_status();
		axw(`LIU_CTRL_OFS, 32'h2);
		axw(`LIU_MASK_OFS, 32'hfe);
		set_los(los ^ 8'h01);
		tick(3);
		chk(irq_n, 1'b1);
		axw(`LIU_MASK_OFS, 32'hff);
		tick(2);
		chk(irq_n, 1'b0);
		chk({irq_oe, irq_o}, 2'b10);
		rd_status();
		tick(2);
		chk({irq_n, irq_oe}, 2'b10);
		set_los(los ^ 8'h08);
		tick(3);
		chk(irq_n, 1'b0);
		// Write one to clear, then the line must float high again
		axw(`LIU_STATUS_OFS, 32'h08);
		status_m = 0;
		tick(2);
		chk(irq_n, 1'b1);
		mode_s <= 1'b1;
		set_los(los ^ 8'h02);
		tick(3);
		chk(irq_n, 1'b1);
		mode_s <= 1'b0;
		tick(3);
		chk(irq_n, 1'b0);
		rd_status();
		// one common rate, clock out follows it
		for (int rt = 0; rt < 3; rt++)
		begin
			axw(`LIU_CTRL_OFS, rt * 16);
			tick(8);
			count_clk(4000, co, cr);
			ex = rt == 1 ? 4000 * `LIU_E1_KHZ / `LIU_ACLK_KHZ : cr;
			chk(co >= ex - 2 && co <= ex + 2, 1'b1);
		end
		summarize();
	end
endmodule
`default_nettype wire
